/* File: rtl/fpc_pkg.sv */
// package of object indices, field positions and encodings for the profile block
package fpc_pkg;
    // object dictionary indices
    localparam logic [15:0] IDX_COMMAND_WORD  = 16'h2051;
    localparam logic [15:0] IDX_REFERENCE_ONE = 16'h2102;
    localparam logic [15:0] IDX_REFERENCE_TWO = 16'h2103;
    localparam logic [15:0] IDX_ACTUAL_ONE    = 16'h2105;
    localparam logic [15:0] IDX_ACTUAL_TWO    = 16'h2106;
    // drive-profile area aliases (values not printed, plain defaults)
    localparam logic [15:0] IDX_ALT_REF_ONE   = 16'h6042;
    localparam logic [15:0] IDX_ALT_REF_TWO   = 16'h6071;
    localparam logic [15:0] IDX_ALT_ACT_ONE   = 16'h6044;
    localparam logic [15:0] IDX_ALT_ACT_TWO   = 16'h6077;
    // command word bit positions
    localparam int BIT_STOP        = 0;
    localparam int BIT_START       = 1;
    localparam int BIT_REVERSE     = 2;
    localparam int BIT_FAULT_RESET = 4;
    localparam int BIT_LOCATION    = 5;
    localparam int BIT_RUN_DISABLE = 6;
    localparam int BIT_NORMAL_STOP = 7;
    localparam int BIT_EMERG_STOP  = 8;
    localparam int BIT_FREE_STOP   = 9;
    localparam int BIT_RAMP_OUT_Z  = 11;
    localparam int BIT_RAMP_HOLD   = 12;
    localparam int BIT_RAMP_IN_Z   = 13;
    // reset values
    localparam logic [15:0] RESET_WORD = 16'h0000;
    // stop mode encoding
    typedef enum logic [1:0] {
        FPC_STOP_NORMAL,
        FPC_STOP_EMERGENCY,
        FPC_STOP_FREEWHEEL
    } fpc_stop_t;
    // scaling type selection per value
    typedef enum logic [1:0] {
        FPC_SCALE_UNITY,
        FPC_SCALE_HALF,
        FPC_SCALE_DOUBLE,
        FPC_SCALE_QUARTER
    } fpc_scale_t;
endpackage : fpc_pkg

/* File: rtl/fpc_control_word.sv */
// fieldbus process data interpreter: references, actual values, command word
//
// Behaviour
// - two references, each taken as 16-bit two's-complement signed integer
// - each reference scaled by its own reference type setting
// - actual values returned as two's-complement words, magnitude limited to 15 bits
// - actual values readable at 2105h/2106h and drive-profile aliases
// - each actual value scaled by its own type setting
// - command word written at 2051h passes unmodified to command logic
// - bit 0 stops with mode from bits 7-9 or configured mode
// - bit 1 commands start, bit 2 reverses direction; zero no action
// - rising edge of bit 4 resets active fault; level does nothing
// - bit 5 selects second location when location source is fieldbus
// - bit 6 high drops run enable when enable source is fieldbus
// - bits 7, 8, 9 request normal, emergency, freewheel stop mode
// - bits 7 to 9 all zero fall back to configured stop mode
// - bit 11 forces ramp generator output to zero
// - bit 12 freezes ramp generator output
// - bit 13 forces ramp generator input to zero
`timescale 1ns/1ps
module fpc_control_word
    import fpc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    // object access from the fieldbus side
    input  wire logic        obj_write,
    input  wire logic        obj_read,
    input  wire logic [15:0] obj_index,
    input  wire logic [15:0] obj_wdata,
    output logic      [15:0] obj_rdata,
    output logic             obj_rvalid,
    output logic             obj_error,
    // configuration
    input  wire logic [1:0]  ref1_type,
    input  wire logic [1:0]  ref2_type,
    input  wire logic [1:0]  actual_value_one_type,
    input  wire logic [1:0]  actual_value_two_type,
    input  wire logic [1:0]  config_stop_mode,
    input  wire logic        location_from_bus,
    input  wire logic        enable_from_bus,
    input  wire logic        fault_active,
    // drive actual values, signed
    input  wire logic [15:0] drive_actual_one,
    input  wire logic [15:0] drive_actual_two,
    // outputs to motor control
    output logic      [15:0] scaled_reference_one,
    output logic      [15:0] scaled_reference_two,
    output logic      [15:0] command_word,
    output logic             stop_command,
    output logic      [1:0]  stop_mode,
    output logic             start_command,
    output logic             reverse_command,
    output logic             fault_reset_pulse,
    output logic             second_location_select,
    output logic             run_enable,
    output logic             ramp_out_zero,
    output logic             ramp_hold,
    output logic             ramp_in_zero
);

    // ------------------------------------------------------------
    // notes on use
    // ------------------------------------------------------------
    // object access is one request per asserted cycle; there is no
    // ready or wait state, so a master may issue a request every clock
    // and a read and a write in the same cycle share one index and one error flag.
    //
    // latency of a write:
    //   edge n   request taken
    //   edge n+1 stored word or reference updated
    //   edge n+2 decoded commands and scaled references updated
    // latency of a read:
    //   edge n   request taken
    //   edge n+1 read data, valid and error shown for one cycle
    //
    // the command word is stored as written, reserved bits included;
    // only the decode stage ignores them, so a later reader of the
    // stored word sees exactly what the master sent.
    //
    // the fault reset edge is found on the stored word, not on the
    // write strobe: writing the same word with bit 4 set twice gives
    // one pulse only, which is what an edge-triggered reset wants.
    // the pulse is also gated by the fault flag, so a rising bit while
    // no fault is present is dropped and not remembered for later.
    //
    // run enable holds its last value while the enable source is not
    // the fieldbus; switching the source back picks up the stored bit
    // on the following edge.
    //
    // doubling saturates instead of wrapping: a wrapped reference
    // would reverse the motor, which is far worse than a clipped one.
    //
    // actual values clamp the magnitude to 15 bits, so the most
    // negative word is returned as its nearest representable value.
    //
    // writes to any index other than the command word or a reference
    // are refused with a one-cycle error; the stored state is kept.
    // reads of anything but an actual value are refused the same way.
    //
    // the drive-profile alias indices share storage with the native
    // ones, so the last write through either index wins.

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // signed scaling by power of two; saturates on double
    function automatic logic [15:0] scale_signed(input logic [15:0] v,
                                                 input logic [1:0]  t);
        logic signed [16:0] wide;
        wide = 17'(signed'(v));
        case (fpc_scale_t'(t))
            FPC_SCALE_UNITY:   scale_signed = v;
            FPC_SCALE_HALF:    scale_signed = 16'(wide >>> 1);
            FPC_SCALE_QUARTER: scale_signed = 16'(wide >>> 2);
            FPC_SCALE_DOUBLE: begin
                wide = wide <<< 1;
                if (wide > 17'sh07FFF)
                    scale_signed = 16'h7FFF;
                else if (wide < -17'sh08000)
                    scale_signed = 16'h8000;
                else
                    scale_signed = 16'(wide);
            end
            default:           scale_signed = v;
        endcase
    endfunction

    // two's complement: magnitude limited to 15 bits, negative is the negated magnitude
    function automatic logic [15:0] to_actual(input logic [15:0] v);
        logic [15:0] mag;
        mag = v[15] ? 16'(-v) : v;
        if (mag > 16'h7FFF)
            mag = 16'h7FFF;
        to_actual = v[15] ? 16'(-mag) : mag;
    endfunction

    // ------------------------------------------------------------
    // write side: references and command word
    // ------------------------------------------------------------
    logic [15:0] reference_one;
    logic [15:0] reference_two;
    logic [15:0] next_reference_one;
    logic [15:0] next_reference_two;
    logic [15:0] next_command_word;
    logic        prev_reset_bit;
    logic        next_prev_reset_bit;

    // decode writes; aliases share storage with the native indices
    always_comb begin
        next_reference_one  = reference_one;
        next_reference_two  = reference_two;
        next_command_word   = command_word;
        next_prev_reset_bit = command_word[BIT_FAULT_RESET];
        if (obj_write) begin
            case (obj_index)
                IDX_REFERENCE_ONE, IDX_ALT_REF_ONE:
                    next_reference_one = obj_wdata;
                IDX_REFERENCE_TWO, IDX_ALT_REF_TWO:
                    next_reference_two = obj_wdata;
                IDX_COMMAND_WORD:
                    next_command_word = obj_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reference_one  <= RESET_WORD;
            reference_two  <= RESET_WORD;
            command_word   <= RESET_WORD;
            prev_reset_bit <= 1'b0;
        end else begin
            reference_one  <= next_reference_one;
            reference_two  <= next_reference_two;
            command_word   <= next_command_word;
            prev_reset_bit <= next_prev_reset_bit;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic [15:0] next_scaled_one;
    logic [15:0] next_scaled_two;
    logic        next_stop;
    logic [1:0]  next_stop_mode;
    logic        next_start;
    logic        next_reverse;
    logic        next_fault_reset;
    logic        next_location;
    logic        next_run_enable;
    logic        next_out_zero;
    logic        next_hold;
    logic        next_in_zero;

    // decoded from the stored word; bits 3, 10, 14, 15 never looked at
    always_comb begin
        next_scaled_one  = scale_signed(reference_one, ref1_type);
        next_scaled_two  = scale_signed(reference_two, ref2_type);
        next_stop        = command_word[BIT_STOP];
        // explicit request bits win over config, normal first
        if (command_word[BIT_NORMAL_STOP])
            next_stop_mode = FPC_STOP_NORMAL;
        else if (command_word[BIT_EMERG_STOP])
            next_stop_mode = FPC_STOP_EMERGENCY;
        else if (command_word[BIT_FREE_STOP])
            next_stop_mode = FPC_STOP_FREEWHEEL;
        else
            next_stop_mode = config_stop_mode;
        next_start       = command_word[BIT_START];
        next_reverse     = command_word[BIT_REVERSE];
        // one-cycle pulse on 0 to 1 only
        next_fault_reset = command_word[BIT_FAULT_RESET]
                           & ~prev_reset_bit & fault_active;
        // when not from fieldbus the location stays at the first
        next_location    = location_from_bus
                           & command_word[BIT_LOCATION];
        next_run_enable  = enable_from_bus
                           ? ~command_word[BIT_RUN_DISABLE]
                           : run_enable;
        next_out_zero    = command_word[BIT_RAMP_OUT_Z];
        next_hold        = command_word[BIT_RAMP_HOLD];
        next_in_zero     = command_word[BIT_RAMP_IN_Z];
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scaled_reference_one   <= RESET_WORD;
            scaled_reference_two   <= RESET_WORD;
            stop_command           <= 1'b0;
            stop_mode              <= FPC_STOP_NORMAL;
            start_command          <= 1'b0;
            reverse_command        <= 1'b0;
            fault_reset_pulse      <= 1'b0;
            second_location_select <= 1'b0;
            run_enable             <= 1'b1;
            ramp_out_zero          <= 1'b0;
            ramp_hold              <= 1'b0;
            ramp_in_zero           <= 1'b0;
        end else begin
            scaled_reference_one   <= next_scaled_one;
            scaled_reference_two   <= next_scaled_two;
            stop_command           <= next_stop;
            stop_mode              <= next_stop_mode;
            start_command          <= next_start;
            reverse_command        <= next_reverse;
            fault_reset_pulse      <= next_fault_reset;
            second_location_select <= next_location;
            run_enable             <= next_run_enable;
            ramp_out_zero          <= next_out_zero;
            ramp_hold              <= next_hold;
            ramp_in_zero           <= next_in_zero;
        end
    end

    // ------------------------------------------------------------
    // read side: actual values
    // ------------------------------------------------------------
    logic [15:0] next_rdata;
    logic        next_rvalid;
    logic        next_error;

    // only the actual values are readable; others answer with error
    always_comb begin
        next_rdata  = 16'h0000;
        next_rvalid = obj_read;
        next_error  = 1'b0;
        if (obj_read) begin
            case (obj_index)
                IDX_ACTUAL_ONE, IDX_ALT_ACT_ONE:
                    next_rdata = to_actual(scale_signed(drive_actual_one,
                                                        actual_value_one_type));
                IDX_ACTUAL_TWO, IDX_ALT_ACT_TWO:
                    next_rdata = to_actual(scale_signed(drive_actual_two,
                                                        actual_value_two_type));
                default:
                    next_error = 1'b1;
            endcase
        end
        if (obj_write && !(obj_index == IDX_COMMAND_WORD
                || obj_index == IDX_REFERENCE_ONE
                || obj_index == IDX_REFERENCE_TWO
                || obj_index == IDX_ALT_REF_ONE
                || obj_index == IDX_ALT_REF_TWO))
            next_error = 1'b1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            obj_rdata  <= 16'h0000;
            obj_rvalid <= 1'b0;
            obj_error  <= 1'b0;
        end else begin
            obj_rdata  <= next_rdata;
            obj_rvalid <= next_rvalid;
            obj_error  <= next_error;
        end
    end

endmodule // fpc_control_word

/* File: testbench/fpc_chk.sv */
// assertion checker for the fieldbus profile block
`timescale 1ns/1ps
module fpc_chk
    import fpc_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        obj_write,
    input wire logic        obj_read,
    input wire logic [15:0] obj_index,
    input wire logic [15:0] obj_wdata,
    input wire logic        obj_rvalid,
    input wire logic        obj_error,
    input wire logic [1:0]  config_stop_mode,
    input wire logic        location_from_bus,
    input wire logic        enable_from_bus,
    input wire logic [15:0] command_word,
    input wire logic        stop_command,
    input wire logic [1:0]  stop_mode,
    input wire logic        start_command,
    input wire logic        reverse_command,
    input wire logic        fault_reset_pulse,
    input wire logic        second_location_select,
    input wire logic        run_enable,
    input wire logic        ramp_out_zero,
    input wire logic        ramp_hold,
    input wire logic        ramp_in_zero
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // write of the command word, which alone moves the stop, start, reverse and ramp outputs
    wire cmd_wr = obj_write && obj_index == IDX_COMMAND_WORD;
    AST_READ_ACK: assert property (obj_read && (obj_index == IDX_ACTUAL_ONE
        || obj_index == IDX_ACTUAL_TWO) |=> obj_rvalid && !obj_error)
        else $error("actual value read not acknowledged");
    AST_CMD_PASS: assert property (cmd_wr |=> command_word == $past(obj_wdata))
        else $error("command word altered");
    AST_BASIC: assert property (cmd_wr |-> ##2 {reverse_command,
        start_command, stop_command} == $past(obj_wdata[2:0], 2))
        else $error("stop start reverse decode wrong");
    AST_RAMP: assert property (cmd_wr |-> ##2 {ramp_in_zero, ramp_hold,
        ramp_out_zero} == $past(obj_wdata[13:11], 2))
        else $error("ramp control decode wrong");
    AST_PULSE: assert property (fault_reset_pulse |-> $past(command_word[4])
        && !$past(command_word[4], 2) ##1 !fault_reset_pulse)
        else $error("fault reset pulse without rising bit");
    AST_LOC: assert property (cmd_wr && location_from_bus ##1 location_from_bus
        |=> second_location_select == $past(obj_wdata[5], 2))
        else $error("location select wrong");
    AST_RUN: assert property (cmd_wr ##1 enable_from_bus
        |=> run_enable == !$past(obj_wdata[6], 2))
        else $error("run enable not following bus");
    AST_RUN_HOLD: assert property (!enable_from_bus |=> $stable(run_enable))
        else $error("run enable moved while bus not its source");
    AST_FALLBACK: assert property (cmd_wr && obj_wdata[9:7] == 3'h0
        |-> ##2 stop_mode == $past(config_stop_mode))
        else $error("configured stop mode not used");
    AST_MODE: assert property (cmd_wr && obj_wdata[9:7] != 3'h0
        |-> ##2 stop_mode == ($past(obj_wdata[7], 2) ? FPC_STOP_NORMAL
        : $past(obj_wdata[8], 2) ? FPC_STOP_EMERGENCY : FPC_STOP_FREEWHEEL))
        else $error("requested stop mode wrong");
    COV_PULSE: cover property (fault_reset_pulse);
    COV_ERR: cover property (obj_error);
    COV_LOC: cover property (second_location_select);
endmodule // fpc_chk

bind fpc_control_word fpc_chk u_chk (.clk, .reset, .obj_write, .obj_read,
    .obj_index, .obj_wdata, .obj_rvalid, .obj_error, .config_stop_mode,
    .location_from_bus, .enable_from_bus, .command_word, .stop_command,
    .stop_mode, .start_command, .reverse_command, .fault_reset_pulse,
    .second_location_select, .run_enable, .ramp_out_zero, .ramp_hold,
    .ramp_in_zero);

/* File: testbench/fpc_master.sv */
// behavioural fieldbus master issuing object writes and reads
`timescale 1ns/1ps
module fpc_master (
    input  wire logic        clk,
    output logic             obj_write,
    output logic             obj_read,
    output logic      [15:0] obj_index,
    output logic      [15:0] obj_wdata
);
    int gap = 0; // idle cycles after each request, a slow master when > 0
    initial begin
        {obj_write, obj_read, obj_index, obj_wdata} = '0;
    end
    // one request per call; released index and data lines show inverted stale values, write and read go low
    task automatic xfer(input logic w, input logic [15:0] idx, dat);
        @(negedge clk);
        obj_write = w;
        obj_read  = !w;
        obj_index = idx;
        obj_wdata = dat;
        @(negedge clk);
        obj_write = 1'b0;
        obj_read  = 1'b0;
        obj_index = ~idx;
        obj_wdata = ~dat;
        repeat (gap) @(negedge clk);
    endtask
endmodule // fpc_master

/* File: testbench/tb.sv */
// self-checking bench for the fieldbus profile block
`timescale 1ns/1ps
module tb;
    import fpc_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        obj_write, obj_read, obj_rvalid, obj_error, run_exp;
    logic [15:0] obj_index, obj_wdata, obj_rdata, d, v, cw;
    logic [1:0]  ref1_type, ref2_type, actual_value_one_type, actual_value_two_type, stop_mode;
    logic [1:0]  config_stop_mode;
    logic        location_from_bus, enable_from_bus, fault_active;
    logic [15:0] drive_actual_one, drive_actual_two, command_word;
    logic [15:0] scaled_reference_one, scaled_reference_two;
    logic        stop_command, start_command, reverse_command, ramp_hold;
    logic        fault_reset_pulse, second_location_select, run_enable;
    logic        ramp_out_zero, ramp_in_zero;
    logic [16:0] notes[$]; // {error expected, data expected}
    logic [16:0] n;
    logic [15:0] words[5] = '{16'h0001, 16'h0081, 16'h0101, 16'h0201,
                              16'hC408};
    int          num_errors = 0, tests_run = 0, cycles = 0, pulses = 0;
    int          seed = 98;
    fpc_master mst (.clk, .obj_write, .obj_read, .obj_index, .obj_wdata);
    fpc_control_word dut (.clk, .reset, .obj_write, .obj_read, .obj_index,
        .obj_wdata, .obj_rdata, .obj_rvalid, .obj_error, .ref1_type,
        .ref2_type, .actual_value_one_type, .actual_value_two_type, .config_stop_mode,
        .location_from_bus, .enable_from_bus, .fault_active,
        .drive_actual_one, .drive_actual_two, .scaled_reference_one,
        .scaled_reference_two, .command_word, .stop_command, .stop_mode,
        .start_command, .reverse_command, .fault_reset_pulse,
        .second_location_select, .run_enable, .ramp_out_zero, .ramp_hold,
        .ramp_in_zero);
    always #5 clk = ~clk;
    // saturating doubling keeps the sign; shifts are arithmetic
    function automatic logic [15:0] scale(logic [15:0] x, logic [1:0] t);
        case (t)
            2'h1: return $signed(x) >>> 1;
            2'h2: return ($signed(x) > 16383) ? 16'h7FFF :
                ($signed(x) < -16384) ? 16'h8000 : x << 1;
            2'h3: return $signed(x) >>> 2;
            default: return x;
        endcase
    endfunction
    task automatic check(string what, logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // answers are matched against the oldest note; also a hang guard
    always @(negedge clk) begin
        cycles++;
        if (fault_reset_pulse === 1'b1) pulses++;
        if (obj_rvalid === 1'b1 || obj_error === 1'b1) begin
            n = notes.pop_front();
            check("error flag", {15'h0, obj_error}, {15'h0, n[16]});
            if (!n[16]) check("read data", obj_rdata, n[15:0]);
        end
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        {ref1_type, ref2_type, actual_value_one_type, actual_value_two_type} = 8'h00;
        {config_stop_mode, location_from_bus, enable_from_bus} = 4'h0;
        {fault_active, drive_actual_one, drive_actual_two} = 33'h0;
        repeat (16) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        check("run enable", {15'h0, run_enable}, 16'h0001);
        run_exp = 1'b1;
        for (int i = 0; i < 45; i++) begin
            d = 16'($random(seed));
            cw = (i < 5) ? words[i] : 16'($random(seed));
            config_stop_mode = (d[1:0] == 2'h3) ? 2'h2 : d[1:0];
            {location_from_bus, enable_from_bus, fault_active} = d[4:2];
            if (enable_from_bus) run_exp = !cw[6];
            mst.xfer(1'b1, IDX_COMMAND_WORD, cw);
            repeat (2) @(negedge clk);
            check("word", command_word, cw);
            check("flags", {8'h0, stop_command, start_command, reverse_command,
                ramp_out_zero, ramp_hold, ramp_in_zero, second_location_select,
                run_enable}, {8'h0, cw[0], cw[1], cw[2], cw[11], cw[12],
                cw[13], cw[5] & location_from_bus, run_exp});
            check("stop mode", {14'h0, stop_mode}, {14'h0, cw[7] ? 2'h0 :
                cw[8] ? 2'h1 : cw[9] ? 2'h2 : config_stop_mode});
        end
        $display("test decode done");
        fault_active = 1'b0;
        mst.xfer(1'b1, IDX_COMMAND_WORD, 16'h0000);
        repeat (3) @(negedge clk);
        pulses = 0;
        mst.xfer(1'b1, IDX_COMMAND_WORD, 16'h0010);
        repeat (3) @(negedge clk);
        check("idle pulses", 16'(pulses), 16'h0000);
        fault_active = 1'b1;
        mst.xfer(1'b1, IDX_COMMAND_WORD, 16'h0000);
        repeat (3) @(negedge clk);
        pulses = 0;
        foreach (words[i]) mst.xfer(1'b1, IDX_COMMAND_WORD, {11'h0, i[0], 4'h0});
        mst.xfer(1'b1, IDX_COMMAND_WORD, 16'h0010);
        repeat (3) @(negedge clk);
        check("pulses", 16'(pulses), 16'h0003);
        $display("test fault reset done");
        for (int t = 0; t < 4; t++) begin
            {ref1_type, ref2_type} = {t[1:0], ~t[1:0]};
            d = (t == 2) ? 16'hC000 : 16'($random(seed));
            v = 16'($random(seed));
            mst.xfer(1'b1, IDX_REFERENCE_ONE, d);
            mst.xfer(1'b1, IDX_ALT_REF_TWO, v);
            repeat (2) @(negedge clk);
            check("ref one", scaled_reference_one, scale(d, t[1:0]));
            check("ref two", scaled_reference_two, scale(v, ~t[1:0]));
            {actual_value_one_type, actual_value_two_type} = {t[1:0], ~t[1:0]};
            drive_actual_one = (t == 0) ? 16'h8000 : 16'($random(seed));
            drive_actual_two = 16'($random(seed));
            v = scale(drive_actual_one, t[1:0]);
            notes.push_back({1'b0, (v == 16'h8000) ? 16'h8001 : v});
            mst.xfer(1'b0, t[0] ? IDX_ALT_ACT_ONE : IDX_ACTUAL_ONE, 16'h0);
            v = scale(drive_actual_two, ~t[1:0]);
            notes.push_back({1'b0, (v == 16'h8000) ? 16'h8001 : v});
            mst.xfer(1'b0, t[0] ? IDX_ACTUAL_TWO : IDX_ALT_ACT_TWO, 16'h0);
        end
        $display("test values done");
        mst.gap = 2;
        notes.push_back(17'h10000);
        mst.xfer(1'b0, IDX_COMMAND_WORD, 16'h0);
        notes.push_back(17'h10000);
        mst.xfer(1'b1, IDX_ACTUAL_ONE, 16'h1234);
        notes.push_back(17'h10000);
        mst.xfer(1'b0, 16'h1234, 16'h0);
        repeat (4) @(negedge clk);
        check("notes left", 16'(notes.size()), 16'h0000);
        $display("test refusals done");
        finish_test();
    end
endmodule // tb
